// >>> verification/sbcw_link_properties.sv
// assertions on the pins between controller and device
// assumes every pin is synchronous to MCLK_IN
`timescale 1ns/1ps
`default_nettype none
module sbcw_link_properties (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic trig_n,
  input wire logic rst_n_o,
  input wire logic rst_n_oe,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [15:0] resp_word,
  input wire logic irq_n
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  logic [7:0] low_q;
  logic [9:0] hi_q;
  logic [15:0] lo_q;
  // cycles the reset pin has been low
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN || rst_n) lo_q <= 16'h0000;
    else if (lo_q != 16'hffff) lo_q <= lo_q + 16'h0001;
  end
  // cycles the trigger has been low
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN || trig_n) low_q <= 8'h00;
    else if (low_q != 8'hff) low_q <= low_q + 8'h01;
  end
  // cycles the reset pin has been high
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN || !rst_n) hi_q <= 10'h000;
    else if (hi_q != 10'h3ff) hi_q <= hi_q + 10'h001;
  end
  property p_od_drive; rst_n_o == 1'b0; endproperty
  a_od_drive: assert property (p_od_drive)
    else $error("reset pin driven high");
  property p_od_level; rst_n == !rst_n_oe; endproperty
  a_od_level: assert property (p_od_level)
    else $error("reset pin level differs from its enable");
  property p_pulse;
    $rose(rst_n) |-> (lo_q >= 16'h0008 && lo_q <= 16'h0021) || lo_q == 16'h4e20;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse length out of range");
  property p_lead; $fell(rst_n) |-> hi_q >= 10'h12b; endproperty
  a_lead: assert property (p_lead)
    else $error("reset came before the lead time ran out");
  property p_trig_width; $rose(trig_n) |-> low_q > 8'h46; endproperty
  a_trig_width: assert property (p_trig_width)
    else $error("trigger pulse too short");
  property p_irq_rise; $rose(irq_n) |-> $past(cmd_valid); endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt released without a command end");
  property p_irq_hold; (!irq_n && !cmd_valid) |=> !irq_n; endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt not held low");
  property p_resp_hold; !$past(cmd_valid) |-> $stable(resp_word); endproperty
  a_resp_hold: assert property (p_resp_hold)
    else $error("status word changed without a command");
endmodule
`default_nettype wire

// >>> verification/sbcw_window_watchdog_pwm_routing_tb.sv
// bench joining controller and device ends over the link
// assumes shortened timing parameters set at the instances
`include "sbcw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sbcw_window_watchdog_pwm_routing_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wake = 1'b0;
  logic txd = 1'b1;
  logic [7:0] cmp = 8'h00;
  logic [15:0] rdata, v;
  logic irq, lin, slope, sleep, wdoff;
  logic [7:0] src;
  logic [2:0] pq[$];
  logic [2:0] p;
  int failures = 0;
  int n_tests = 0;
  int seed = 32'h246d;
  int i, t;
  always #50 clk = ~clk;
  sbcw_link_if sbcw_link_if_inst ();
  sbcw_device #(.OSC_CYC(40), .STARTUP_CYC(20), .LEAD_CYC(300),
    .TXTO_CYC(50)) sbcw_device_inst (.MCLK_IN(clk), .SRST_IN(srst), .WAKE_IN(wake),
    .TXD_IN(txd), .CMP_IN(cmp), .LIN_OUT(lin), .SLOPE_OFF_OUT(slope), .SLEEP_OUT(sleep),
    .WD_OFF_OUT(wdoff), .SRC_ON_OUT(src), .link(sbcw_link_if_inst));
  sbcw_host #(.MS_CYC(10)) sbcw_host_inst (.MCLK_IN(clk), .SRST_IN(srst),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .IRQ_OUT(irq), .link(sbcw_link_if_inst));
  sbcw_link_properties sbcw_link_properties_inst (.MCLK_IN(clk), .SRST_IN(srst),
    .trig_n(sbcw_link_if_inst.trig_n), .rst_n_o(sbcw_link_if_inst.rst_n_o),
    .rst_n_oe(sbcw_link_if_inst.rst_n_oe), .rst_n(sbcw_link_if_inst.rst_n),
    .cmd_valid(sbcw_link_if_inst.cmd_valid), .resp_word(sbcw_link_if_inst.resp_word),
    .irq_n(sbcw_link_if_inst.irq_n));
  // expected source levels for a pwm pattern
  function automatic logic [7:0] route(input logic [2:0] pw);
    int map [8] = '{0, 1, 2, 2, 1, 1, 0, 0};
    for (int k = 0; k < 8; k++) route[k] = pw[map[k]];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic send(input logic [15:0] c);
    wr_reg(`SBCW_A_TX, c);
    cyc(3);
  endtask
  task automatic wait_pin(input logic lvl, output int n);
    n = 0;
    while (sbcw_link_if_inst.rst_n !== lvl && n < 25000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("pin_level", {15'h0000, lvl}, {15'h0000, sbcw_link_if_inst.rst_n});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(40000);
    failures++;
    $display("MISMATCH watchdog expected finish seen hang");
    conclude();
  end
  initial begin
    cyc(20);
    srst <= 1'b0;
    @(posedge clk);
    rd_reg(`SBCW_A_LINK, v);
    chk("link_reset", 16'h0002, v);
    txd <= 1'b0;
    rd_reg(4'h8, v);
    chk("unmapped", 16'h0000, v);
    chk("lin_idle", 16'h0001, {15'h0000, lin});
    chk("outs_reset", 16'h0000, {5'h00, slope, sleep, wdoff, src});
    txd <= 1'b1;
    $display("test reset done");
    wait_pin(1'b1, t);
    wait_pin(1'b0, t);
    chk("lead", 16'h0001, {15'h0000, t >= 299 && t <= 302});
    wait_pin(1'b1, t);
    chk("pulse", 16'h0001,
      {15'h0000, t >= `SBCW_RST_PULSE_CYC && t <= `SBCW_RST_PULSE_CYC + 1});
    rd_reg(`SBCW_A_STS, v);
    chk("sts_rst", 16'h0004, v);
    chk("irq_masked", 16'h0000, {15'h0000, irq});
    wr_reg(`SBCW_A_MASK, 16'h0004);
    cyc(2);
    chk("irq_on", 16'h0001, {15'h0000, irq});
    wr_reg(`SBCW_A_STS, 16'h0004);
    cyc(2);
    chk("irq_clr", 16'h0000, {15'h0000, irq});
    $display("test expiry done");
    send(16'h1401);
    wr_reg(`SBCW_A_PERIOD, 16'h000f);
    wr_reg(`SBCW_A_CTRL, 16'h0001);
    wr_reg(`SBCW_A_STS, 16'h0007);
    for (i = 0; i < 40; i++) begin
      v = 16'($random(seed));
      txd <= v[0];
      @(posedge clk);
      #1 chk("lin_follow", {15'h0000, v[0]}, {15'h0000, lin});
    end
    txd <= 1'b0;
    cyc(60);
    chk("lin_timeout", 16'h0001, {15'h0000, lin});
    send(16'h1407);
    cyc(60);
    chk("lin_long", 16'h0000, {15'h0000, lin});
    chk("slope_off", 16'h0001, {15'h0000, slope});
    txd <= 1'b1;
    send(16'h4001);
    send(16'h1407);
    chk("wdd_single", 16'h0000, {15'h0000, wdoff});
    wr_reg(`SBCW_A_WDOFF, 16'h0000);
    cyc(4);
    chk("wdd_pair", 16'h0001, {15'h0000, wdoff});
    send(16'h4000);
    chk("wdd_clear", 16'h0000, {15'h0000, wdoff});
    cyc(1000);
    rd_reg(`SBCW_A_STS, v);
    chk("alive", 16'h0000, {15'h0000, v[2]});
    $display("test trigger done");
    send(16'h1410);
    chk("sleep", 16'h0001, {15'h0000, sleep});
    wr_reg(`SBCW_A_CTRL, 16'h0002);
    wr_reg(`SBCW_A_STS, 16'h0007);
    cyc(600);
    rd_reg(`SBCW_A_STS, v);
    chk("sleep_quiet", 16'h0000, {15'h0000, v[2]});
    wake <= 1'b1;
    cyc(3);
    wake <= 1'b0;
    wait_pin(1'b0, t);
    wait_pin(1'b1, t);
    chk("awake", 16'h0000, {15'h0000, sleep});
    chk("strap_off", 16'h0001, {15'h0000, wdoff});
    wr_reg(`SBCW_A_STS, 16'h0007);
    cyc(800);
    rd_reg(`SBCW_A_STS, v);
    chk("strap_quiet", 16'h0000, {15'h0000, v[2]});
    $display("test sleep done");
    for (i = 0; i < 8; i++) send(16'h2001 | (16'(i) << 8));
    for (i = 0; i < 8; i++) pq.push_back(3'(i));
    for (i = 0; i < 6; i++) pq.push_back(3'($random(seed)));
    while (pq.size() > 0) begin
      p = pq.pop_front();
      wr_reg(`SBCW_A_CTRL, {11'h000, p, 2'b00});
      cyc(3);
      chk("route", {8'h00, route(p)}, {8'h00, src});
    end
    wr_reg(`SBCW_A_CTRL, 16'h0000);
    send(16'h2003);
    chk("internal", 16'h0001, {15'h0000, src[0]});
    $display("test routing done");
    send(16'h2005);
    wr_reg(`SBCW_A_CTRL, 16'h0004);
    wr_reg(`SBCW_A_CTRL, 16'h0000);
    cmp <= 8'h01;
    wr_reg(`SBCW_A_CTRL, 16'h0004);
    wr_reg(`SBCW_A_CTRL, 16'h0000);
    cyc(20);
    rd_reg(`SBCW_A_LINK, v);
    chk("irq_low", 16'h0001, v);
    rd_reg(`SBCW_A_STS, v);
    chk("irq_flag", 16'h0001, {15'h0000, v[1]});
    send(16'h30ff);
    rd_reg(`SBCW_A_LINK, v);
    chk("irq_end", 16'h0003, v);
    $display("test interrupt done");
    conclude();
  end
endmodule
`default_nettype wire

// >>> verilog/sbcw_device.sv
// device end: window watchdog, LIN control, source routing
// assumes link inputs synchronous to MCLK_IN
//
// Notes on behaviour
// - host trigger falls once per window
// - trigger low pulse longer than 7 us
// - missed trigger asserts active-low reset
// - watchdog timing from internal oscillator period
// - watchdog stopped during sleep
// - disable bit needs two consecutive words
// - divider pin high at start-up disables
// - 155 ms lead before first trigger
// - after wake, lead starts at reset rise
// - LIN inactive until commanded on
// - slope-off setting for high-speed LIN
// - enabled LIN follows transmit input
// - setting disables transmit dominant time-out
// - fixed PWM input to source routing
// - cleared control bit selects PWM drive
// - sample comparator at control falling edge
// - interrupt low until next command end
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "sbcw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sbcw_device
  import sbcw_pkg::*;
#(
  parameter int unsigned OSC_CYC = `SBCW_OSC_CYC,
  parameter int unsigned STARTUP_CYC = `SBCW_STARTUP_CYC,
  parameter int unsigned LEAD_CYC = `SBCW_LEAD_CYC,
  parameter int unsigned RST_PULSE_CYC = `SBCW_RST_PULSE_CYC,
  parameter int unsigned TXTO_CYC = `SBCW_TXTO_CYC
) (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic WAKE_IN,
  input wire logic TXD_IN,
  input wire logic [7:0] CMP_IN,
  output logic LIN_OUT,
  output logic SLOPE_OFF_OUT,
  output logic SLEEP_OUT,
  output logic WD_OFF_OUT,
  output logic [7:0] SRC_ON_OUT,
  sbcw_link_if.dev link
);
  localparam int unsigned TMIN = `SBCW_TRIG_MIN_CYC;

  // PWM input that feeds source i
  function automatic logic pwm_of(input logic [2:0] i, input logic [2:0] p);
    case (i)
      3'd0, 3'd6, 3'd7: pwm_of = p[0];
      3'd1, 3'd4, 3'd5: pwm_of = p[1];
      default: pwm_of = p[2];
    endcase
  endfunction

  logic [15:0] w;
  logic [3:0] op;
  logic cmd;
  logic lin_en_q, to_dis_q, sleep_q;
  logic [3:0] win_q;
  logic wdd_q, wdd_pend_q, strap_q, strap_ok_q;
  logic [7:0] cse_q, csc_q, csie_q, smp_q, flag_q, flag_set, flag_d, src_d;
  logic irq_q;
  logic trig_prev_q, trig_ok;
  logic [23:0] low_cnt_q, cnt_q, osc_cnt_q, dom_cnt_q;
  logic [3:0] win_cnt_q;
  logic osc_tick, wd_off, to_hit;
  sbcw_wd_state_type state_q;

  assign w = link.cmd_word;
  assign op = w[`SBCW_OP_MSB:`SBCW_OP_LSB];
  assign cmd = link.cmd_valid;
  assign wd_off = wdd_q | strap_q;

  // configuration word
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      lin_en_q <= 1'b0;
      SLOPE_OFF_OUT <= 1'b0;
      to_dis_q <= 1'b0;
      sleep_q <= 1'b0;
      win_q <= `SBCW_WIN_RESET;
    end else if (cmd && op == `SBCW_OP_CFG) begin
      lin_en_q <= w[`SBCW_CFG_LIN_EN];
      SLOPE_OFF_OUT <= w[`SBCW_CFG_SLOPE_OFF];
      to_dis_q <= w[`SBCW_CFG_TO_DIS];
      sleep_q <= w[`SBCW_CFG_SLEEP];
      win_q <= w[`SBCW_CFG_WIN_MSB:`SBCW_CFG_WIN_LSB];
    end else if (sleep_q && WAKE_IN) begin
      sleep_q <= 1'b0;
    end
  end

  // disable bit, two consecutive writes
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      wdd_q <= 1'b0;
      wdd_pend_q <= 1'b0;
    end else if (cmd) begin
      if (op == `SBCW_OP_WDD && w[`SBCW_WDD_BIT]) begin
        wdd_pend_q <= 1'b1;
        if (wdd_pend_q) begin
          wdd_q <= 1'b1;
        end
      end else begin
        wdd_pend_q <= 1'b0;
        if (op == `SBCW_OP_WDD) begin
          wdd_q <= 1'b0;
        end
      end
    end
  end

  // per-source configuration
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      cse_q <= 8'h00;
      csc_q <= 8'h00;
      csie_q <= 8'h00;
    end else if (cmd && op == `SBCW_OP_SRC) begin
      cse_q[w[`SBCW_SRC_IDX_MSB:`SBCW_SRC_IDX_LSB]] <= w[`SBCW_SRC_CSE];
      csc_q[w[`SBCW_SRC_IDX_MSB:`SBCW_SRC_IDX_LSB]] <= w[`SBCW_SRC_CSC];
      csie_q[w[`SBCW_SRC_IDX_MSB:`SBCW_SRC_IDX_LSB]] <= w[`SBCW_SRC_CSIE];
    end
  end

  // source drive and comparator sampling
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      src_d[i] = cse_q[i] & (csc_q[i] | pwm_of(3'(i), link.pwm));
      flag_set[i] = SRC_ON_OUT[i] & ~src_d[i] & (CMP_IN[i] != smp_q[i]) & csie_q[i];
    end
    flag_d = flag_q | flag_set;
    if (cmd && op == `SBCW_OP_CLR) begin
      flag_d = (flag_q & ~w[7:0]) | flag_set;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      SRC_ON_OUT <= 8'h00;
      smp_q <= 8'h00;
      flag_q <= 8'h00;
    end else begin
      SRC_ON_OUT <= src_d;
      flag_q <= flag_d;
      for (int i = 0; i < 8; i++) begin
        if (SRC_ON_OUT[i] && !src_d[i]) begin
          smp_q[i] <= CMP_IN[i];
        end
      end
    end
  end

  // interrupt pin and command answer
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      irq_q <= 1'b0;
      link.irq_n <= 1'b1;
      link.resp_word <= 16'h0000;
    end else begin
      if (|flag_set) begin
        irq_q <= 1'b1;
        link.irq_n <= 1'b0;
      end else if (cmd) begin
        irq_q <= |(flag_d & csie_q);
        link.irq_n <= ~|(flag_d & csie_q);
      end
      if (cmd) begin
        link.resp_word <= {flag_q, smp_q};
      end
    end
  end

  // LIN transmit path with dominant time-out
  assign to_hit = !to_dis_q && dom_cnt_q >= 24'(TXTO_CYC);
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      dom_cnt_q <= 24'h00_0000;
      LIN_OUT <= 1'b1;
    end else begin
      dom_cnt_q <= TXD_IN ? 24'h00_0000 : (to_hit ? dom_cnt_q : dom_cnt_q + 24'h00_0001);
      // follow transmit input; idle while off
      LIN_OUT <= (lin_en_q && !sleep_q) ? (TXD_IN | to_hit) : 1'b1;
    end
  end

  // trigger width check
  assign trig_ok = !trig_prev_q && link.trig_n && low_cnt_q >= 24'(TMIN);
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      trig_prev_q <= 1'b1;
      low_cnt_q <= 24'h00_0000;
    end else begin
      trig_prev_q <= link.trig_n;
      if (link.trig_n) begin
        low_cnt_q <= 24'h00_0000;
      end else if (low_cnt_q < 24'(TMIN)) begin
        low_cnt_q <= low_cnt_q + 24'h00_0001;
      end
    end
  end

  // oscillator time base; stopped in sleep
  assign osc_tick = osc_cnt_q == 24'(OSC_CYC - 1);
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN || state_q != ST_WIN || trig_ok || osc_tick) begin
      osc_cnt_q <= 24'h00_0000;
    end else begin
      osc_cnt_q <= osc_cnt_q + 24'h00_0001;
    end
  end

  // watchdog sequence
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      state_q <= ST_START;
      cnt_q <= 24'h00_0000;
      win_cnt_q <= 4'h0;
      strap_q <= 1'b0;
      strap_ok_q <= 1'b1;
    end else begin
      case (state_q)
        ST_START: begin
          strap_ok_q <= strap_ok_q & link.div_hi;
          cnt_q <= cnt_q + 24'h00_0001;
          if (cnt_q == 24'(STARTUP_CYC - 1)) begin
            strap_q <= strap_ok_q & link.div_hi;
            cnt_q <= 24'h00_0000;
            state_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (sleep_q) begin
            state_q <= ST_SLEEP;
          end else if (trig_ok) begin
            win_cnt_q <= 4'h0;
            state_q <= ST_WIN;
          end else if (!wd_off) begin
            cnt_q <= cnt_q + 24'h00_0001;
            if (cnt_q == 24'(LEAD_CYC - 1)) begin
              cnt_q <= 24'h00_0000;
              state_q <= ST_RST;
            end
          end
        end
        ST_WIN: begin
          if (sleep_q) begin
            state_q <= ST_SLEEP;
          end else if (trig_ok) begin
            win_cnt_q <= 4'h0;
          end else if (osc_tick && !wd_off) begin
            if (win_cnt_q + 4'h1 >= win_q) begin
              cnt_q <= 24'h00_0000;
              state_q <= ST_RST;
            end else begin
              win_cnt_q <= win_cnt_q + 4'h1;
            end
          end
        end
        ST_RST: begin
          cnt_q <= cnt_q + 24'h00_0001;
          if (cnt_q == 24'(RST_PULSE_CYC - 1)) begin
            cnt_q <= 24'h00_0000;
            state_q <= ST_LEAD;
          end
        end
        ST_SLEEP: begin
          // wake restarts start-up, lead at reset rise
          if (!sleep_q) begin
            cnt_q <= 24'h00_0000;
            strap_ok_q <= 1'b1;
            state_q <= ST_START;
          end
        end
        default: state_q <= ST_START;
      endcase
    end
  end

  // reset pin and status outputs
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      link.rst_n_oe <= 1'b1;
      link.rst_n_o <= 1'b0;
      WD_OFF_OUT <= 1'b0;
      SLEEP_OUT <= 1'b0;
    end else begin
      link.rst_n_oe <= state_q == ST_START || state_q == ST_RST;
      link.rst_n_o <= 1'b0;
      WD_OFF_OUT <= wd_off;
      SLEEP_OUT <= sleep_q;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sbcw_host.sv
// controller end: triggers, strap, PWM levels, command words
// software reaches it through a plain register port
`include "sbcw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sbcw_host
  import sbcw_pkg::*;
#(
  parameter int unsigned MS_CYC = `SBCW_MS_CYC,
  parameter int unsigned TRIG_LOW_CYC = `SBCW_TRIG_LOW_CYC
) (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  output logic IRQ_OUT,
  sbcw_link_if.host link
);
  logic [4:0] ctrl_q;
  logic [15:0] period_q, rx_q, per_cnt_q;
  logic [2:0] sts_q, mask_q, sts_set, sts_d;
  logic second_q, got_q, irq_prev_q, rst_prev_q, ms_tick;
  logic [23:0] ms_cnt_q, low_cnt_q;

  // control registers
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      ctrl_q <= 5'h00;
      period_q <= `SBCW_PERIOD_RESET;
      mask_q <= 3'h0;
    end else if (WR_IN) begin
      if (ADDR_IN == `SBCW_A_CTRL) begin
        ctrl_q <= WDATA_IN[4:0];
      end
      if (ADDR_IN == `SBCW_A_PERIOD) begin
        period_q <= WDATA_IN;
      end
      if (ADDR_IN == `SBCW_A_MASK) begin
        mask_q <= WDATA_IN[2:0];
      end
    end
  end

  assign link.div_hi = ctrl_q[`SBCW_CTRL_STRAP];
  assign link.pwm = ctrl_q[`SBCW_CTRL_PWM_MSB:`SBCW_CTRL_PWM_LSB];

  // command words
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      link.cmd_valid <= 1'b0;
      link.cmd_word <= 16'h0000;
      second_q <= 1'b0;
      got_q <= 1'b0;
      rx_q <= 16'h0000;
    end else begin
      got_q <= link.cmd_valid;
      if (got_q) begin
        rx_q <= link.resp_word;
      end
      link.cmd_valid <= 1'b0;
      if (second_q) begin
        link.cmd_valid <= 1'b1;
        link.cmd_word <= `SBCW_WDD_WORD;
        second_q <= 1'b0;
      end else if (WR_IN && ADDR_IN == `SBCW_A_WDOFF) begin
        link.cmd_valid <= 1'b1;
        link.cmd_word <= `SBCW_WDD_WORD;
        second_q <= 1'b1;
      end else if (WR_IN && ADDR_IN == `SBCW_A_TX) begin
        link.cmd_valid <= 1'b1;
        link.cmd_word <= WDATA_IN;
      end
    end
  end

  // status, write one to clear, set wins
  always_comb begin
    sts_set = {rst_prev_q & ~link.rst_n, irq_prev_q & ~link.irq_n, got_q};
    sts_d = sts_q | sts_set;
    if (WR_IN && ADDR_IN == `SBCW_A_STS) begin
      sts_d = (sts_q & ~WDATA_IN[2:0]) | sts_set;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      sts_q <= 3'h0;
      irq_prev_q <= 1'b1;
      rst_prev_q <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_prev_q <= link.irq_n;
      rst_prev_q <= link.rst_n;
      IRQ_OUT <= |(sts_d & mask_q);
    end
  end

  // read port
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `SBCW_A_CTRL: RDATA_OUT <= {11'h000, ctrl_q};
        `SBCW_A_PERIOD: RDATA_OUT <= period_q;
        `SBCW_A_RX: RDATA_OUT <= rx_q;
        `SBCW_A_STS: RDATA_OUT <= {13'h0000, sts_q};
        `SBCW_A_MASK: RDATA_OUT <= {13'h0000, mask_q};
        `SBCW_A_LINK: RDATA_OUT <= {14'h0000, link.irq_n, link.rst_n};
        default: RDATA_OUT <= 16'h0000;
      endcase
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  // trigger generator, restarts while reset pin is low
  assign ms_tick = ms_cnt_q == 24'(MS_CYC - 1);
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      ms_cnt_q <= 24'h00_0000;
      per_cnt_q <= 16'h0000;
      low_cnt_q <= 24'h00_0000;
      link.trig_n <= 1'b1;
    end else if (!ctrl_q[`SBCW_CTRL_TRIG_EN] || !link.rst_n || period_q == 16'h0000) begin
      // first trigger timed from reset rise
      ms_cnt_q <= 24'h00_0000;
      per_cnt_q <= 16'h0000;
      low_cnt_q <= 24'h00_0000;
      link.trig_n <= 1'b1;
    end else begin
      // period keeps counting through the low pulse
      ms_cnt_q <= ms_tick ? 24'h00_0000 : ms_cnt_q + 24'h00_0001;
      if (!link.trig_n) begin
        low_cnt_q <= low_cnt_q + 24'h00_0001;
        if (low_cnt_q == 24'(TRIG_LOW_CYC - 1)) begin
          link.trig_n <= 1'b1;
        end
      end
      if (ms_tick) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
        if (per_cnt_q == period_q - 16'h0001) begin
          per_cnt_q <= 16'h0000;
          low_cnt_q <= 24'h00_0000;
          link.trig_n <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sbcw_link_if.sv
// pins between controller and device
// reset pin is open drain with a pull-up resolved here
`timescale 1ns/1ps
`default_nettype none
interface sbcw_link_if;
  logic trig_n;
  logic rst_n_o;
  logic rst_n_oe;
  logic rst_n;
  logic [2:0] pwm;
  logic div_hi;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic [15:0] resp_word;
  logic irq_n;
  // open-drain wire with pull-up
  assign rst_n = ~(rst_n_oe & ~rst_n_o);
  modport dev (
    input trig_n, pwm, div_hi, cmd_valid, cmd_word,
    output rst_n_o, rst_n_oe, resp_word, irq_n
  );
  modport host (
    output trig_n, pwm, div_hi, cmd_valid, cmd_word,
    input rst_n, resp_word, irq_n
  );
endinterface
`default_nettype wire

// >>> verilog/sbcw_params.svh
// constants of the watchdog / switch-interface control pair
// assumes a 100 ns clock; counts derive from printed times
`ifndef SBCW_PARAMS_SVH
`define SBCW_PARAMS_SVH
`define SBCW_CLK_NS 100
`define SBCW_TRIG_MIN_NS 7000
`define SBCW_TRIG_MIN_CYC ((`SBCW_TRIG_MIN_NS + `SBCW_CLK_NS - 1) / `SBCW_CLK_NS)
`define SBCW_TRIG_LOW_CYC (`SBCW_TRIG_MIN_CYC + 1)
`define SBCW_STARTUP_MS 4
`define SBCW_STARTUP_CYC (`SBCW_STARTUP_MS * 1000000 / `SBCW_CLK_NS)
`define SBCW_LEAD_MS 155
`define SBCW_LEAD_CYC (`SBCW_LEAD_MS * 1000000 / `SBCW_CLK_NS)
`define SBCW_OSC_MIN_MS 20
`define SBCW_OSC_MAX_MS 64
`define SBCW_OSC_CYC (`SBCW_OSC_MIN_MS * 1000000 / `SBCW_CLK_NS)
`define SBCW_RST_PULSE_MS 2
`define SBCW_RST_PULSE_CYC (`SBCW_RST_PULSE_MS * 1000000 / `SBCW_CLK_NS)
`define SBCW_TXTO_MS 10
`define SBCW_TXTO_CYC (`SBCW_TXTO_MS * 1000000 / `SBCW_CLK_NS)
`define SBCW_MS_CYC (1000000 / `SBCW_CLK_NS)
// command word layout
`define SBCW_OP_MSB 15
`define SBCW_OP_LSB 12
`define SBCW_OP_CFG 4'h1
`define SBCW_OP_SRC 4'h2
`define SBCW_OP_CLR 4'h3
`define SBCW_OP_WDD 4'h4
`define SBCW_CFG_LIN_EN 0
`define SBCW_CFG_SLOPE_OFF 1
`define SBCW_CFG_TO_DIS 2
`define SBCW_CFG_SLEEP 4
`define SBCW_CFG_WIN_LSB 8
`define SBCW_CFG_WIN_MSB 11
`define SBCW_WIN_RESET 4'h2
`define SBCW_SRC_CSE 0
`define SBCW_SRC_CSC 1
`define SBCW_SRC_CSIE 2
`define SBCW_SRC_IDX_LSB 8
`define SBCW_SRC_IDX_MSB 10
`define SBCW_WDD_BIT 0
`define SBCW_WDD_WORD 16'h4001
// host register map
`define SBCW_A_CTRL 4'h0
`define SBCW_A_PERIOD 4'h1
`define SBCW_A_TX 4'h2
`define SBCW_A_RX 4'h3
`define SBCW_A_STS 4'h4
`define SBCW_A_MASK 4'h5
`define SBCW_A_LINK 4'h6
`define SBCW_A_WDOFF 4'h7
`define SBCW_CTRL_TRIG_EN 0
`define SBCW_CTRL_STRAP 1
`define SBCW_CTRL_PWM_LSB 2
`define SBCW_CTRL_PWM_MSB 4
`define SBCW_PERIOD_RESET 16'h0000
`endif

// >>> verilog/sbcw_pkg.sv
// types shared by both ends
// no assumptions beyond a SystemVerilog compiler
`default_nettype none
package sbcw_pkg;
  typedef enum logic [2:0] {
    ST_START,
    ST_LEAD,
    ST_WIN,
    ST_RST,
    ST_SLEEP
  } sbcw_wd_state_type;
endpackage
`default_nettype wire
